// ==== rtl/eag_regs.svh ====
// Behaviour
// - Accumulator mode is a one-byte instruction acting on the accumulator, with no operand or address fetch.
// - Immediate mode hands the second instruction byte straight out as the operand, with no memory access.
// - Absolute mode builds the address from the second byte (low) and third byte (high).
// - Zero page mode uses the second byte as the low address and forces the high byte to zero.
// - Indexed zero page adds the second byte to the chosen index and drops the carry, staying in page zero.
// - Indexed absolute adds X or Y to the 16-bit base taken from bytes two and three.
// - Implied mode takes its operand from the opcode alone and fetches no address bytes.
// - Relative mode adds the signed second byte (-128 to +127) to the program counter of the next instruction.
// - Indexed indirect adds byte two to X without carry, then reads the address low and high in page zero.
// - Indirect indexed reads a page-zero pointer, adds Y to its low byte and carries into the next byte.
// - Absolute indirect reads a 16-bit pointer's two bytes and loads them into the program counter.
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH
`define EAG_PAGE_ZERO 8'h00
`define EAG_ADDR_NONE 16'h0000
`define EAG_BYTE_NONE 8'h00
`define EAG_ZP_STEP 8'h01
`define EAG_PTR_STEP 16'h0001
`define EAG_SIGN_BIT 7
`endif

// ==== rtl/eag_pkg.sv ====
package eag_pkg;
  typedef enum logic [3:0] {
    EAG_ACC = 4'h0,
    EAG_IMM = 4'h1,
    EAG_ABS = 4'h2,
    EAG_ZPG = 4'h3,
    EAG_ZPX = 4'h4,
    EAG_ZPY = 4'h5,
    EAG_ABX = 4'h6,
    EAG_ABY = 4'h7,
    EAG_IMP = 4'h8,
    EAG_REL = 4'h9,
    EAG_INX = 4'hA,
    EAG_INY = 4'hB,
    EAG_IND = 4'hC
  } eag_mode_e;

  typedef enum logic [1:0] {
    EAG_IDLE = 2'h0,
    EAG_RD_LO = 2'h1,
    EAG_RD_HI = 2'h3,
    EAG_FIN = 2'h2
  } eag_state_e;

  typedef struct packed {
    eag_mode_e mode;
    logic [7:0] op2;
    logic [7:0] op3;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
    logic [15:0] pc_next;
  } eag_req_s;

  typedef struct packed {
    logic done;
    logic [15:0] ea;
    logic [7:0] operand;
    logic use_operand;
    logic use_acc;
    logic pc_load;
  } eag_res_s;

  typedef struct packed {
    eag_state_e st;
    eag_req_s req;
    logic [7:0] lo;
    logic busy;
    logic mem_req;
    logic [15:0] mem_addr;
    eag_res_s res;
  } eag_st_s;
endpackage

// ==== rtl/eag_top.sv ====
`timescale 1ns/1ps
`include "eag_regs.svh"
module eag_top import eag_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire eag_req_s req,
  output logic busy,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output eag_res_s res
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Pointer step that wraps inside page zero
  function automatic logic [15:0] zp_next(input logic [7:0] b);
    logic [7:0] n;
    n = b + `EAG_ZP_STEP;
    return {`EAG_PAGE_ZERO, n};
  endfunction

  eag_st_s s_r;
  eag_st_s s_nxt;
  logic [8:0] sum9;
  logic [7:0] idx_sel;
  logic [7:0] hi_sum;

  assign busy = s_r.busy;
  assign mem_req = s_r.mem_req;
  assign mem_addr = s_r.mem_addr;
  assign res = s_r.res;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.res.done = 1'b0;
    sum9 = {1'b0, s_r.lo} + {1'b0, s_r.req.idx_y};
    hi_sum = mem_rdata + {7'h00, sum9[8]};
    idx_sel = (req.mode == EAG_ZPY || req.mode == EAG_ABY) ? req.idx_y : req.idx_x;
    case (s_r.st)
      EAG_IDLE: begin
        if (start) begin
          s_nxt.req = req;
          s_nxt.res.ea = `EAG_ADDR_NONE;
          s_nxt.res.operand = `EAG_BYTE_NONE;
          s_nxt.res.use_operand = 1'b0;
          s_nxt.res.use_acc = 1'b0;
          s_nxt.res.pc_load = 1'b0;
          s_nxt.res.done = 1'b1;
          case (req.mode)
            EAG_ACC: begin
              s_nxt.res.use_acc = 1'b1;
            end
            EAG_IMM: begin
              s_nxt.res.operand = req.op2;
              s_nxt.res.use_operand = 1'b1;
            end
            EAG_ABS: begin
              s_nxt.res.ea = {req.op3, req.op2};
            end
            EAG_ZPG: begin
              s_nxt.res.ea = {`EAG_PAGE_ZERO, req.op2};
            end
            EAG_ZPX, EAG_ZPY: begin
              // Carry dropped by the 8-bit sum
              s_nxt.res.ea = {`EAG_PAGE_ZERO, 8'(req.op2 + idx_sel)};
            end
            EAG_ABX, EAG_ABY: begin
              // Full 16-bit add so page crossings carry
              s_nxt.res.ea = {req.op3, req.op2} + {`EAG_PAGE_ZERO, idx_sel};
            end
            EAG_IMP: begin
              s_nxt.res.ea = `EAG_ADDR_NONE;
            end
            EAG_REL: begin
              s_nxt.res.ea = req.pc_next + {{8{req.op2[`EAG_SIGN_BIT]}}, req.op2};
            end
            EAG_INX: begin
              s_nxt.res.done = 1'b0;
              s_nxt.busy = 1'b1;
              s_nxt.mem_req = 1'b1;
              s_nxt.mem_addr = {`EAG_PAGE_ZERO, 8'(req.op2 + req.idx_x)};
              s_nxt.st = EAG_RD_LO;
            end
            EAG_INY: begin
              s_nxt.res.done = 1'b0;
              s_nxt.busy = 1'b1;
              s_nxt.mem_req = 1'b1;
              s_nxt.mem_addr = {`EAG_PAGE_ZERO, req.op2};
              s_nxt.st = EAG_RD_LO;
            end
            EAG_IND: begin
              s_nxt.res.done = 1'b0;
              s_nxt.busy = 1'b1;
              s_nxt.mem_req = 1'b1;
              s_nxt.mem_addr = {req.op3, req.op2};
              s_nxt.st = EAG_RD_LO;
            end
            default: begin
              s_nxt.res.ea = `EAG_ADDR_NONE;
            end
          endcase
        end
      end
      EAG_RD_LO: begin
        if (mem_ack) begin
          s_nxt.lo = mem_rdata;
          s_nxt.st = EAG_RD_HI;
          if (s_r.req.mode == EAG_IND) begin
            // Pointer itself steps linearly to the next location
            s_nxt.mem_addr = s_r.mem_addr + `EAG_PTR_STEP;
          end else begin
            s_nxt.mem_addr = zp_next(s_r.mem_addr[7:0]);
          end
        end
      end
      EAG_RD_HI: begin
        if (mem_ack) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.st = EAG_FIN;
          if (s_r.req.mode == EAG_INY) begin
            s_nxt.res.ea = {hi_sum, sum9[7:0]};
          end else begin
            s_nxt.res.ea = {mem_rdata, s_r.lo};
          end
          s_nxt.res.pc_load = (s_r.req.mode == EAG_IND);
        end
      end
      EAG_FIN: begin
        s_nxt.res.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st = EAG_IDLE;
      end
      default: begin
        s_nxt.st = EAG_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic idle_start;
  assign idle_start = start && !busy;

  a_acc_no_fetch: assert property (idle_start && req.mode == EAG_ACC |=> res.done && res.use_acc && !mem_req)
    else $error("accumulator mode misbehaved");
  a_imm_operand: assert property (idle_start && req.mode == EAG_IMM
    |=> res.use_operand && res.operand == $past(req.op2) && !mem_req)
    else $error("immediate operand wrong");
  a_abs_addr: assert property (idle_start && req.mode == EAG_ABS
    |=> res.done && res.ea == {$past(req.op3), $past(req.op2)})
    else $error("absolute address wrong");
  a_zpg_addr: assert property (idle_start && req.mode == EAG_ZPG
    |=> res.ea[15:8] == `EAG_PAGE_ZERO && res.ea[7:0] == $past(req.op2))
    else $error("zero page address wrong");
  a_zpx_wrap: assert property (idle_start && req.mode == EAG_ZPX
    |=> res.ea == {`EAG_PAGE_ZERO, 8'($past(req.op2) + $past(req.idx_x))})
    else $error("indexed zero page left page zero");
  a_zpy_wrap: assert property (idle_start && req.mode == EAG_ZPY
    |=> res.ea == {`EAG_PAGE_ZERO, 8'($past(req.op2) + $past(req.idx_y))})
    else $error("indexed zero page Y left page zero");
  a_aby_carry: assert property (idle_start && req.mode == EAG_ABY
    |=> res.ea == {$past(req.op3), $past(req.op2)} + {`EAG_PAGE_ZERO, $past(req.idx_y)})
    else $error("indexed absolute address wrong");
  a_abx_addr: assert property (idle_start && req.mode == EAG_ABX
    |=> res.ea == {$past(req.op3), $past(req.op2)} + {`EAG_PAGE_ZERO, $past(req.idx_x)})
    else $error("indexed absolute X address wrong");
  a_abx_cross: assert property (idle_start && req.mode == EAG_ABX && (9'(req.op2) + 9'(req.idx_x)) > 9'h0FF
    |=> res.ea[15:8] == 8'($past(req.op3) + 8'h01))
    else $error("page crossing carry lost");
  a_imp_nofetch: assert property (idle_start && req.mode == EAG_IMP |=> res.done ##1 !mem_req)
    else $error("implied mode fetched");
  a_rel_target: assert property (idle_start && req.mode == EAG_REL
    |=> res.ea == $past(req.pc_next) + {{8{$past(req.op2[`EAG_SIGN_BIT])}}, $past(req.op2)})
    else $error("branch target wrong");
  a_inx_ptr: assert property (idle_start && req.mode == EAG_INX
    |=> mem_req && mem_addr == {`EAG_PAGE_ZERO, 8'($past(req.op2) + $past(req.idx_x))})
    else $error("indexed indirect pointer wrong");
  a_iny_hi_zp: assert property (s_r.st == EAG_RD_LO && mem_ack && s_r.req.mode == EAG_INY
    |=> mem_addr[15:8] == `EAG_PAGE_ZERO)
    else $error("indirect indexed pointer left page zero");
  a_ind_pcload: assert property (s_r.st == EAG_RD_HI && mem_ack && s_r.req.mode == EAG_IND
    |=> res.pc_load ##1 res.done)
    else $error("absolute indirect did not load counter");

  // ---------------------------------------------------------------
  // Pointer walk checks
  // ---------------------------------------------------------------
  // Watched on the state register, since the bus alone hides which byte is read
  a_inx_hi_wrap: assert property (s_r.st == EAG_RD_LO && mem_ack && s_r.req.mode == EAG_INX
    |=> mem_req && mem_addr == {`EAG_PAGE_ZERO, 8'($past(mem_addr[7:0]) + `EAG_ZP_STEP)})
    else $error("indexed indirect high byte left page zero");
  a_ind_ptr_step: assert property (s_r.st == EAG_RD_LO && mem_ack && s_r.req.mode == EAG_IND
    |=> mem_req && mem_addr == $past(mem_addr) + `EAG_PTR_STEP)
    else $error("absolute indirect pointer did not step");
  a_iny_sum: assert property (s_r.st == EAG_RD_HI && mem_ack && s_r.req.mode == EAG_INY
    |=> res.ea == {$past(mem_rdata), $past(s_r.lo)} + {`EAG_PAGE_ZERO, $past(s_r.req.idx_y)})
    else $error("indirect indexed address wrong");
  a_ptr_release: assert property (s_r.st == EAG_FIN |=> res.done && !busy && !mem_req)
    else $error("pointer walk did not finish");

  c_iny_walk: cover property (idle_start && req.mode == EAG_INY ##[2:20] res.done);
  c_ind_walk: cover property (idle_start && req.mode == EAG_IND ##[2:20] res.pc_load);
  c_abx_cross: cover property (idle_start && req.mode == EAG_ABX && req.op2 == 8'hFF && req.idx_x != 8'h00);
  c_zpx_wrap: cover property (idle_start && req.mode == EAG_ZPX && (9'(req.op2) + 9'(req.idx_x)) > 9'h0FF);
  c_iny_carry: cover property (s_r.st == EAG_RD_HI && mem_ack && s_r.req.mode == EAG_INY && sum9[8]);

endmodule

// ==== test/eag_mem_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Program and data memory seen over the bus
// ----------------------------------------
module eag_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [1:0] cnt_r = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;
  always @(negedge ref_clk) begin
    if (mem_req && cnt_r == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
      cnt_r <= slow ? 2'h2 : 2'h0;
    end else begin
      mem_ack <= 1'b0;
      // Stale data flips so a late read cannot pass by luck
      mem_rdata <= ~mem_rdata;
      if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ==== test/tb_effective_address_generator.sv ====
`timescale 1ns/1ps
module tb_effective_address_generator import eag_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  eag_req_s req = '0;
  logic busy, mem_req, mem_ack;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  eag_res_s res;
  int fail_count = 0;
  int n_checks = 0;
  logic hung = 1'b0;
  logic [15:0] lfsr_r = 16'h804D;
  always #5 ref_clk = ~ref_clk;
  eag_top eag_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .start(start), .req(req), .busy(busy),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .res(res));
  eag_mem_model eag_mem_model_i (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
// ----------------------------------------
// Expectations
// ----------------------------------------
  function automatic logic [15:0] lfsr_step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] mb(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [15:0] exp_ea(eag_req_s r);
    logic [8:0] s;
    s = {1'b0, mb({8'h00, r.op2})} + {1'b0, r.idx_y};
    case (r.mode)
      EAG_ABS: return {r.op3, r.op2};
      EAG_ZPG: return {8'h00, r.op2};
      EAG_ZPX: return {8'h00, r.op2 + r.idx_x};
      EAG_ZPY: return {8'h00, r.op2 + r.idx_y};
      EAG_ABX: return {r.op3, r.op2} + {8'h00, r.idx_x};
      EAG_ABY: return {r.op3, r.op2} + {8'h00, r.idx_y};
      EAG_REL: return r.pc_next + {{8{r.op2[7]}}, r.op2};
      EAG_INX: return {mb({8'h00, r.op2 + r.idx_x + 8'h01}), mb({8'h00, r.op2 + r.idx_x})};
      EAG_INY: return {mb({8'h00, r.op2 + 8'h01}) + {7'h00, s[8]}, s[7:0]};
      EAG_IND: return {mb({r.op3, r.op2} + 16'h0001), mb({r.op3, r.op2})};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check_eq(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
// ----------------------------------------
// One request, optionally poked while busy
// ----------------------------------------
  task automatic run(input eag_req_s r, input logic poke);
    int n;
    logic any_req;
    logic ptr;
    logic busy1;
    logic [2:0] flg;
    // Let an edge pass so start and req never change twice in one step
    @(negedge ref_clk);
    ptr = r.mode inside {EAG_INX, EAG_INY, EAG_IND};
    flg = {r.mode == EAG_ACC, r.mode == EAG_IMM, r.mode == EAG_IND};
    any_req = 1'b0;
    busy1 = 1'b0;
    req = r;
    start = 1'b1;
    for (n = 1; n <= 40; n++) begin
      @(negedge ref_clk);
      // A second start inside the walk must be ignored
      start = (n == 1) && poke && ptr;
      if (n == 1) begin
        req.mode = EAG_ABS;
        busy1 = busy;
      end
      any_req |= mem_req;
      if (res.done === 1'b1) begin
        break;
      end
    end
    if (n > 40) begin
      fail_count++;
      hung = 1'b1;
    end else begin
      check_eq({15'h0, any_req}, {15'h0, ptr});
      if (r.mode != EAG_ACC && r.mode != EAG_IMM) check_eq(res.ea, exp_ea(r));
      check_eq({13'h0, res.use_acc, res.use_operand, res.pc_load}, {13'h0, flg});
      if (r.mode == EAG_IMM) check_eq({8'h00, res.operand}, {8'h00, r.op2});
      if (ptr && !slow) check_eq(16'(n), 16'h0004);
      check_eq({14'h0, busy1, busy}, {14'h0, ptr, 1'b0});
    end
  endtask
  initial begin
    eag_req_s r;
    logic [63:0] rnd;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    // Carries and page wraps at every boundary but the indexed indirect pointer step
    for (int m = 0; m < 16 && !hung; m++) begin
      r = '{mode: eag_mode_e'(m), op2: 8'hFF, op3: 8'h12, idx_x: 8'h01, idx_y: 8'hFF, pc_next: 16'h0000};
      run(r, 1'b1);
    end
    for (int k = 0; k < 300 && !hung; k++) begin
      repeat (4) begin
        lfsr_r = lfsr_step(lfsr_r);
        rnd = {rnd[47:0], lfsr_r};
      end
      slow <= rnd[52];
      run(eag_req_s'(rnd[51:0]), rnd[53]);
    end
    close_out();
  end
endmodule
